// *** src/aer_regs.sv ***
// Purpose: Error severity, correctable status/mask, capability and header log
// Assumes: APB master; error pulses come from logic on clk
// Notes:   Sticky state resets only on power-on reset (por_n)
//
// Function
// - Sticky severity bits, fatal when set
// - Receiver error sets correctable bit 0
// - Bad TLP bit 6, bad DLLP bit 7
// - Rollover bit 8, replay timeout bit 12
// - Correctable mask blocks header logging, interrupts and messages, not status
// - First error pointer holds first bit position
// - ECRC generate and check capable read one
// - Generate ECRC only while bit 6 set
// - Check ECRC only while bit 8 set
// - Header log captures four big-endian doublewords
// - Uncorrectable status set, severity picks fatality
`timescale 1ns/1ps
module aer_regs
    import aer_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         por_n,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [31:0]  unc_err_evt,
    input  wire logic [31:0]  cor_err_evt,
    input  wire logic [127:0] err_hdr,
    output logic              ecrc_gen_en,
    output logic              ecrc_chk_en,
    output logic              msg_cor,
    output logic              msg_nonfatal,
    output logic              msg_fatal,
    output logic              irq
);
    // Sticky storage, cleared by power-on only
    logic [31:0]  sev_reg;        // Severity per uncorrectable error
    logic [31:0]  unc_stat_reg;   // Uncorrectable status, W1C
    logic [31:0]  unc_mask_in;    // Uncorrectable mask lives elsewhere
    logic [31:0]  cor_stat_reg;   // Correctable status, W1C
    logic [31:0]  cor_mask_reg;   // Correctable mask
    logic [4:0]   fep_reg;        // First error pointer
    logic         fep_valid_reg;  // Pointer holds a live error
    logic         gen_en_reg;     // ECRC generation enable
    logic         chk_en_reg;     // ECRC check enable
    logic [127:0] hdr_reg;        // Header log
    // Ordinary reset domain
    logic [AER_IRQ_W-1:0] irq_stat_reg; // Sticky interrupt events
    logic [AER_IRQ_W-1:0] irq_en_reg;   // Interrupt enables
    // Bus decode
    logic         wr_acc;         // Write takes effect this edge
    logic         rd_acc;         // Read answer this edge
    logic [31:0]  rd_data;        // Read mux
    logic         addr_ok;        // Mapped address
    // Event qualification
    logic [31:0]  unc_new;        // Implemented uncorrectable events
    logic [31:0]  unc_logged;     // Unmasked uncorrectable events
    logic [31:0]  cor_new;        // Implemented correctable events
    logic [31:0]  cor_logged;     // Unmasked correctable events
    logic [31:0]  w1c_unc;        // Software clear, uncorrectable
    logic [31:0]  w1c_cor;        // Software clear, correctable
    logic [4:0]   first_pos;      // Lowest new logged position
    logic         any_fatal;      // Unmasked fatal event
    logic         any_nonfatal;   // Unmasked non-fatal event
    logic         any_cor;        // Unmasked correctable event

    // The uncorrectable mask register sits outside this bank; all unmasked here
    // Limitation: no uncorrectable masking until that register is joined in
    assign unc_mask_in = 32'h0000_0000;

    // One wait state: the access is taken while ready is still low
    assign wr_acc = psel && penable && pwrite && addr_ok && !pready;
    // Taking a write once keeps a clear from landing again on the ready edge
    assign rd_acc = psel && penable && !pwrite;

    // Address decode
    always_comb begin
        unique case (paddr)
            AER_OFF_UNC_STAT, AER_OFF_UNC_SEV, AER_OFF_COR_STAT,
            AER_OFF_COR_MASK, AER_OFF_CAP_CTRL, AER_OFF_IRQ_STAT,
            AER_OFF_IRQ_CLR, AER_OFF_IRQ_EN: addr_ok = 1'b1;
            default: begin
                // Header log words are a contiguous run
                addr_ok = (paddr >= AER_OFF_HDR_LOG0) && (paddr <= AER_OFF_HDR_LOG3)
                          && (paddr[1:0] == 2'b00);
            end
        endcase
    end

    // Event qualification
    always_comb begin
        unc_new    = unc_err_evt & AER_UNC_BITS;
        cor_new    = cor_err_evt & AER_COR_BITS;
        cor_logged = cor_new & ~cor_mask_reg;
        unc_logged = unc_new & ~unc_mask_in;
        w1c_unc    = (wr_acc && paddr == AER_OFF_UNC_STAT) ? pwdata : 32'h0000_0000;
        w1c_cor    = (wr_acc && paddr == AER_OFF_COR_STAT) ? pwdata : 32'h0000_0000;
        any_fatal    = |(unc_logged & sev_reg);
        any_nonfatal = |(unc_logged & ~sev_reg);
        any_cor      = |cor_logged;
        first_pos    = 5'h00;
        // Lowest position wins when several arrive together
        for (int i = 31; i >= 0; i--) begin
            if (unc_logged[i]) begin
                first_pos = 5'(i);
            end
        end
    end

    // Severity register
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            sev_reg <= AER_SEV_RESET;
        end else if (wr_acc && paddr == AER_OFF_UNC_SEV) begin
            sev_reg <= pwdata & AER_UNC_BITS;
        end
    end

    // Uncorrectable status, set wins over clear
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            unc_stat_reg <= 32'h0000_0000;
        end else begin
            unc_stat_reg <= ((unc_stat_reg & ~w1c_unc) | unc_new) & AER_UNC_BITS;
        end
    end

    // Correctable status, set wins over clear
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            cor_stat_reg <= 32'h0000_0000;
        end else begin
            cor_stat_reg <= ((cor_stat_reg & ~w1c_cor) | cor_new) & AER_COR_BITS;
        end
    end

    // Correctable mask
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            cor_mask_reg <= 32'h0000_0000;
        end else if (wr_acc && paddr == AER_OFF_COR_MASK) begin
            cor_mask_reg <= pwdata & AER_COR_BITS;
        end
    end

    // ECRC enables
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            gen_en_reg <= 1'b0;
            chk_en_reg <= 1'b0;
        end else if (wr_acc && paddr == AER_OFF_CAP_CTRL) begin
            gen_en_reg <= pwdata[AER_GEN_EN_BIT];
            chk_en_reg <= pwdata[AER_CHK_EN_BIT];
        end
    end

    // First error pointer; re-arms once its status bit is cleared
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            fep_reg       <= AER_FEP_RESET;
            fep_valid_reg <= 1'b0;
        end else if (!fep_valid_reg || !unc_stat_reg[fep_reg]) begin
            if (|unc_logged) begin
                fep_reg       <= first_pos;
                fep_valid_reg <= 1'b1;
            end else begin
                fep_valid_reg <= 1'b0;
            end
        end
    end

    // Header log; the source presents each dword byte 0 in bits 31:24
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            hdr_reg <= 128'h0;
        end else if ((|unc_logged && (!fep_valid_reg || !unc_stat_reg[fep_reg]))
                     || (any_cor && !fep_valid_reg)) begin
            hdr_reg <= err_hdr;
        end
    end

    // Interrupt status, ordinary reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_reg <= '0;
        end else begin
            // Set wins over clear
            irq_stat_reg <= (irq_stat_reg
                & ~((wr_acc && paddr == AER_OFF_IRQ_CLR) ? pwdata[AER_IRQ_W-1:0] : 3'h0))
                | {any_fatal, any_nonfatal, any_cor};
        end
    end

    // Interrupt enable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_en_reg <= '0;
        end else if (wr_acc && paddr == AER_OFF_IRQ_EN) begin
            irq_en_reg <= pwdata[AER_IRQ_W-1:0];
        end
    end

    // Read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (paddr)
            AER_OFF_UNC_STAT: rd_data = unc_stat_reg;
            AER_OFF_UNC_SEV:  rd_data = sev_reg;
            AER_OFF_COR_STAT: rd_data = cor_stat_reg;
            AER_OFF_COR_MASK: rd_data = cor_mask_reg;
            AER_OFF_CAP_CTRL: begin
                rd_data[AER_FEP_LSB +: AER_FEP_W] = fep_reg;
                rd_data[AER_GEN_CAP_BIT] = 1'b1;
                rd_data[AER_CHK_CAP_BIT] = 1'b1;
                rd_data[AER_GEN_EN_BIT]  = gen_en_reg;
                rd_data[AER_CHK_EN_BIT]  = chk_en_reg;
            end
            AER_OFF_IRQ_STAT: rd_data = {29'h0, irq_stat_reg};
            AER_OFF_IRQ_EN:   rd_data = {29'h0, irq_en_reg};
            default: begin
                // Header log dword select; others read zero
                if (addr_ok && paddr != AER_OFF_IRQ_CLR) begin
                    rd_data = hdr_reg[127 - 32*((paddr - AER_OFF_HDR_LOG0) >> 2) -: 32];
                end
            end
        endcase
    end

    // APB answer: one wait state, ready rises the cycle after penable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Ready pulses once; its own feedback keeps it from repeating
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
            // Data stands only with ready, zero otherwise
            prdata  <= (rd_acc && !pready) ? rd_data : 32'h0000_0000;
        end
    end

    // ECRC enables to the datapath, one cycle after the control bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ecrc_gen_en <= 1'b0;
            ecrc_chk_en <= 1'b0;
        end else begin
            ecrc_gen_en <= gen_en_reg;
            ecrc_chk_en <= chk_en_reg;
        end
    end

    // Error messages toward the root side, one pulse per event cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            msg_cor      <= 1'b0;
            msg_nonfatal <= 1'b0;
            msg_fatal    <= 1'b0;
        end else begin
            msg_cor      <= any_cor;
            msg_nonfatal <= any_nonfatal;
            msg_fatal    <= any_fatal;
        end
    end

    // Level interrupt; registered so the pin never glitches
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            // Any enabled sticky event holds the line high
            irq <= |(irq_stat_reg & irq_en_reg);
        end
    end
endmodule

// *** src/aer_pkg.sv ***
// Purpose: Constants for the advanced error reporting register bank
// Assumes: APB slave, 32-bit data, byte addresses as printed
// Notes:   Offsets, field positions and reset values live here only
package aer_pkg;
    // Register byte offsets
    localparam logic [11:0] AER_OFF_UNC_SEV   = 12'h10c;
    localparam logic [11:0] AER_OFF_COR_STAT  = 12'h110;
    localparam logic [11:0] AER_OFF_COR_MASK  = 12'h114;
    localparam logic [11:0] AER_OFF_CAP_CTRL  = 12'h118;
    localparam logic [11:0] AER_OFF_HDR_LOG0  = 12'h11c;
    localparam logic [11:0] AER_OFF_HDR_LOG3  = 12'h128;
    localparam logic [11:0] AER_OFF_UNC_STAT  = 12'h104;
    localparam logic [11:0] AER_OFF_IRQ_STAT  = 12'h130;
    localparam logic [11:0] AER_OFF_IRQ_CLR   = 12'h134;
    localparam logic [11:0] AER_OFF_IRQ_EN    = 12'h138;
    // Implemented bits of each register, and severity reset value
    localparam logic [31:0] AER_UNC_BITS      = 32'h001f_f011;
    localparam logic [31:0] AER_COR_BITS      = 32'h0000_11c1;
    localparam logic [31:0] AER_SEV_RESET     = 32'h0006_2011;
    // Capability and control fields
    localparam int          AER_FEP_LSB       = 0;
    localparam int          AER_FEP_W         = 5;
    localparam int          AER_GEN_CAP_BIT   = 5;
    localparam int          AER_GEN_EN_BIT    = 6;
    localparam int          AER_CHK_CAP_BIT   = 7;
    localparam int          AER_CHK_EN_BIT    = 8;
    localparam logic [4:0]  AER_FEP_RESET     = 5'h00;
    // Correctable event bit positions
    localparam int          AER_COR_RX_ERR    = 0;
    localparam int          AER_COR_BAD_TLP   = 6;
    localparam int          AER_COR_BAD_DLLP  = 7;
    localparam int          AER_COR_ROLLOVER  = 8;
    localparam int          AER_COR_TIMEOUT   = 12;
    // Interrupt status layout: bit0 correctable, bit1 non-fatal, bit2 fatal
    localparam int          AER_IRQ_W         = 3;
endpackage

// *** tb/aer_regs_props.sv ***
// Purpose: Port checks for the error register bank
// Assumes: One clock; either reset disables the checks
// Notes:   Messages and enables are checked against their causes
`timescale 1ns/1ps
module aer_regs_chk
    import aer_pkg::*;
(
    input wire logic         clk,
    input wire logic         reset_n,
    input wire logic         por_n,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [31:0]  prdata,
    input wire logic [31:0]  unc_err_evt,
    input wire logic [31:0]  cor_err_evt,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic         ecrc_gen_en,
    input wire logic         ecrc_chk_en,
    input wire logic         msg_cor,
    input wire logic         msg_nonfatal,
    input wire logic         msg_fatal,
    input wire logic         irq,
    input wire logic [127:0] err_hdr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n || !por_n);
    logic       cfg_wr;   // Access phase write to control word
    logic [1:0] up_cnt;   // Cycles since reset, saturating
    logic       cor_hit;  // Any used correctable event
    logic       unc_hit;  // Any used uncorrectable event
    assign cfg_wr = psel && penable && pwrite && paddr == AER_OFF_CAP_CTRL;
    assign cor_hit = |(cor_err_evt & AER_COR_BITS);
    assign unc_hit = |(unc_err_evt & AER_UNC_BITS);
    // Outputs reload after reset, so hold off the follow checks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) up_cnt <= 2'h0;
        else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end
    sequence s_acc;
        psel && penable && !pready;
    endsequence
    a_one_wait: assert property (s_acc |=> pready)
        else $error("ready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_cor_cause: assert property (msg_cor |-> $past(cor_hit) || $past(cor_hit, 2))
        else $error("correctable message without event");
    a_fatal_cause: assert property (msg_fatal |-> $past(unc_hit) || $past(unc_hit, 2))
        else $error("fatal message without event");
    a_nf_cause: assert property (msg_nonfatal |-> $past(unc_hit) || $past(unc_hit, 2))
        else $error("non-fatal message without event");
    a_gen_follow: assert property (up_cnt[1] && $changed(ecrc_gen_en) |->
        $past(cfg_wr) || $past(cfg_wr, 2)) else $error("generate enable moved alone");
    a_chk_follow: assert property (up_cnt[1] && $changed(ecrc_chk_en) |->
        $past(cfg_wr) || $past(cfg_wr, 2)) else $error("check enable moved alone");
endmodule
bind aer_regs aer_regs_chk aer_regs_chk_inst (.clk(clk), .reset_n(reset_n), .por_n(por_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .unc_err_evt(unc_err_evt), .cor_err_evt(cor_err_evt),
    .pready(pready), .pslverr(pslverr), .ecrc_gen_en(ecrc_gen_en), .ecrc_chk_en(ecrc_chk_en),
    .msg_cor(msg_cor), .msg_nonfatal(msg_nonfatal), .msg_fatal(msg_fatal), .irq(irq),
    .err_hdr(err_hdr));

// *** tb/aer_link_model.sv ***
// Purpose: Link-side error detectors and message sink
// Assumes: Events are one-cycle pulses on clk
// Notes:   Header bus shows inverted data outside events
`timescale 1ns/1ps
module aer_link_model (
    input  wire logic         clk,
    input  wire logic         msg_cor,
    input  wire logic         msg_nonfatal,
    input  wire logic         msg_fatal,
    output logic      [31:0]  cor_err_evt,
    output logic      [31:0]  unc_err_evt,
    output logic      [127:0] err_hdr
);
    int n_cor = 0;  // Correctable messages seen
    int n_nf  = 0;  // Non-fatal messages seen
    int n_fat = 0;  // Fatal messages seen
    initial begin
        cor_err_evt = '0;
        unc_err_evt = '0;
        err_hdr = '0;
    end
    // One pulse; header goes stale afterwards so a late capture shows
    task automatic fire(input logic [31:0] c, u, input logic [127:0] h);
        @(posedge clk);
        cor_err_evt <= c;
        unc_err_evt <= u;
        err_hdr <= h;
        @(posedge clk);
        cor_err_evt <= '0;
        unc_err_evt <= '0;
        err_hdr <= ~h;
    endtask
    // Count messages toward the root side
    always @(posedge clk) begin
        n_cor <= n_cor + int'(msg_cor);
        n_nf <= n_nf + int'(msg_nonfatal);
        n_fat <= n_fat + int'(msg_fatal);
    end
endmodule

// *** tb/tb_aer_regs.sv ***
// Purpose: Register, event and reset checks of the error bank
// Assumes: APB master per transfer, events from the link model
// Notes:   Expected values built from package constants
`timescale 1ns/1ps
module tb_aer_regs;
    import aer_pkg::*;
    logic clk = 0, reset_n = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, cor_err_evt, unc_err_evt;
    logic [127:0] err_hdr;
    logic pready, pslverr, ecrc_gen_en, ecrc_chk_en, msg_cor, msg_nonfatal, msg_fatal, irq;
    int miscompares = 0, checks_done = 0, cyc = 0;
    int cbits[5] = '{AER_COR_RX_ERR, AER_COR_BAD_TLP, AER_COR_BAD_DLLP,
                     AER_COR_ROLLOVER, AER_COR_TIMEOUT};
    localparam logic [127:0] H1 = 128'h00112233_44556677_8899aabb_ccddeeff;
    localparam logic [127:0] H2 = 128'hfedcba98_76543210_0f1e2d3c_4b5a6978;
    aer_regs aer_regs_inst (.clk(clk), .reset_n(reset_n), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .unc_err_evt(unc_err_evt),
        .cor_err_evt(cor_err_evt), .err_hdr(err_hdr), .ecrc_gen_en(ecrc_gen_en),
        .ecrc_chk_en(ecrc_chk_en), .msg_cor(msg_cor), .msg_nonfatal(msg_nonfatal),
        .msg_fatal(msg_fatal), .irq(irq));
    aer_link_model aer_link_model_inst (.clk(clk), .msg_cor(msg_cor),
        .msg_nonfatal(msg_nonfatal), .msg_fatal(msg_fatal), .cor_err_evt(cor_err_evt),
        .unc_err_evt(unc_err_evt), .err_hdr(err_hdr));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard, well above the run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic chk_word(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask
    // Setup, access, hold until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk_word(q, x);
        chk_bit(e, xe);
    endtask
    // Dword 0 sits in the top bits of the captured header
    task automatic rd_log(input logic [127:0] h);
        for (int k = 0; k < 4; k++) rd(AER_OFF_HDR_LOG0 + 12'(4 * k), h[127 - 32 * k -: 32], 0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1;
        por_n <= 1;
        rd(AER_OFF_UNC_SEV, AER_SEV_RESET, 0);
        rd(AER_OFF_COR_STAT, 32'h0, 0);
        rd(AER_OFF_CAP_CTRL, 32'h0000_00a0, 0);
        chk_bit(ecrc_gen_en | ecrc_chk_en, 0);
        wr(AER_OFF_UNC_SEV, '1);
        rd(AER_OFF_UNC_SEV, AER_UNC_BITS, 0);
        wr(AER_OFF_CAP_CTRL, '1);
        rd(AER_OFF_CAP_CTRL, 32'h0000_01e0, 0);
        chk_bit(ecrc_chk_en, 1);
        wr(AER_OFF_CAP_CTRL, 32'h0000_0040);
        rd(AER_OFF_CAP_CTRL, 32'h0000_00e0, 0);
        chk_bit(ecrc_chk_en, 0);
        for (int i = 0; i < 5; i++) begin
            aer_link_model_inst.fire(32'h1 << cbits[i], 32'h0, H1);
            rd(AER_OFF_COR_STAT, 32'h1 << cbits[i], 0);
            chk_word(32'(aer_link_model_inst.n_cor), 32'(i + 1));
            wr(AER_OFF_COR_STAT, 32'h1 << cbits[i]);
            rd(AER_OFF_COR_STAT, 32'h0, 0);
        end
        rd_log(H1);
        rd(AER_OFF_IRQ_STAT, 32'h1, 0);
        chk_bit(irq, 0);
        wr(AER_OFF_IRQ_EN, 32'h7);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1);
        wr(AER_OFF_IRQ_CLR, 32'h1);
        repeat (2) @(posedge clk);
        chk_bit(irq, 0);
        wr(AER_OFF_COR_MASK, '1);
        rd(AER_OFF_COR_MASK, AER_COR_BITS, 0);
        aer_link_model_inst.fire(AER_COR_BITS, 32'h0, H2);
        rd(AER_OFF_COR_STAT, AER_COR_BITS, 0);
        chk_word(32'(aer_link_model_inst.n_cor), 32'h5);
        rd_log(H1);
        wr(AER_OFF_UNC_SEV, 32'h0000_2000);
        aer_link_model_inst.fire(32'h0, 32'h0000_3000, H2);
        rd(AER_OFF_UNC_STAT, 32'h0000_3000, 0);
        rd(AER_OFF_CAP_CTRL, 32'h0000_00ec, 0);
        rd_log(H2);
        chk_word(32'(aer_link_model_inst.n_fat), 32'h1);
        rd(AER_OFF_IRQ_STAT, 32'h6, 0);
        chk_bit(irq, 1);
        aer_link_model_inst.fire(32'h0, 32'h0000_0010, H1);
        rd(AER_OFF_CAP_CTRL, 32'h0000_00ec, 0);
        chk_word(32'(aer_link_model_inst.n_nf), 32'h2);
        @(posedge clk);
        reset_n <= 0;
        @(posedge clk);
        reset_n <= 1;
        rd(AER_OFF_UNC_SEV, 32'h0000_2000, 0);
        rd(AER_OFF_COR_MASK, AER_COR_BITS, 0);
        rd(AER_OFF_COR_STAT, AER_COR_BITS, 0);
        rd(AER_OFF_IRQ_STAT, 32'h0, 0);
        chk_bit(ecrc_gen_en, 1);
        rd(12'h200, 32'h0, 1);
        @(posedge clk);
        por_n <= 0;
        reset_n <= 0;
        @(posedge clk);
        por_n <= 1;
        reset_n <= 1;
        rd(AER_OFF_UNC_SEV, AER_SEV_RESET, 0);
        rd(AER_OFF_COR_STAT, 32'h0, 0);
        rd(AER_OFF_UNC_STAT, 32'h0, 0);
        rd(AER_OFF_CAP_CTRL, 32'h0000_00a0, 0);
        chk_bit(ecrc_gen_en, 0);
        rd_log(128'h0);
        stop_test();
    end
endmodule
